//--- verification/mccs_bus_agent.sv
// Data-space bus agent standing for the instruction side of the core.
`timescale 1ns/1ps
module mccs_bus_agent (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output mccs_pkg::mccs_bus_s bus_req
);
  import mccs_pkg::*;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_req <= '0;
    end else if (go) begin
      bus_req <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    end else begin
      // Idle lines show the inverse of the last value so stale data never looks valid.
      bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~bus_req.addr, wdata: ~bus_req.wdata};
    end
  end
endmodule // mccs_bus_agent

//--- verification/mccs_core_checker.sv
// Concurrent checks on the ports of the core context and stack block.
`timescale 1ns/1ps
module mccs_core_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input mccs_pkg::mccs_bus_s bus_req,
  input mccs_pkg::mccs_pc_cmd_s pc_cmd,
  input mccs_pkg::mccs_flag_upd_s flag_upd,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_hit,
  input wire logic [11:0] pc,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] index_pointer_first,
  input wire logic [7:0] short_direct_first,
  input wire logic zero_flag,
  input mccs_pkg::mccs_ctx_e context_now,
  input wire logic [2:0] stack_depth,
  input wire logic machine_tick,
  input wire logic periph_tick
);
  import mccs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  acc_read_a:
    assert property (bus_req.rd && bus_req.addr == 8'hFF |=> bus_hit
      && bus_rdata == $past(accumulator)) else $error("Accumulator read wrong.");
  ptr_write_a:
    assert property (bus_req.wr && bus_req.addr == 8'h80 |=>
      index_pointer_first == $past(bus_req.wdata)) else $error("Pointer write lost.");
  short_write_a:
    assert property (bus_req.wr && bus_req.addr == 8'h82 |=>
      short_direct_first == $past(bus_req.wdata)) else $error("Short write lost.");
  core_tick_a:
    assert property (machine_tick |=> !machine_tick [*8] ##4 !machine_tick ##1 machine_tick)
      else $error("Machine tick period wrong.");
  periph_tick_a:
    assert property (periph_tick |-> ##12 periph_tick) else $error("Periph tick period wrong.");
  pc_hold_a:
    assert property (!machine_tick |=> pc == $past(pc)) else $error("Counter moved off tick.");
  pc_call_a:
    assert property (machine_tick && pc_cmd.op == PC_CALL |=> pc == $past(pc_cmd.target)
      && stack_depth == ($past(stack_depth) == 3'h6 ? 3'h6 : $past(stack_depth) + 3'h1))
      else $error("Call result wrong.");
  pc_branch_a:
    assert property (machine_tick && pc_cmd.op == PC_BRANCH |=> pc == $past(pc)
      + {{4{$past(pc_cmd.offset[7])}}, $past(pc_cmd.offset)}) else $error("Branch wrong.");
  ret_empty_a:
    assert property (machine_tick && pc_cmd.op == PC_RET && stack_depth == 3'h0 |=>
      pc == $past(pc) + 12'h001 && stack_depth == 3'h0) else $error("Empty return wrong.");
  zero_upd_a:
    assert property (flag_upd.zero_en && !machine_tick |=>
      zero_flag == ($past(flag_upd.result) == 8'h00)) else $error("Zero flag wrong.");
  int_enter_a:
    assert property (machine_tick && pc_cmd.op == PC_INT && context_now == CTX_NORMAL |=>
      context_now == CTX_INT) else $error("Interrupt context not entered.");
endmodule // mccs_core_checker

bind mccs_core_state mccs_core_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .bus_req(bus_req), .pc_cmd(pc_cmd), .flag_upd(flag_upd), .bus_rdata(bus_rdata),
  .bus_hit(bus_hit), .pc(pc), .accumulator(accumulator),
  .index_pointer_first(index_pointer_first), .short_direct_first(short_direct_first),
  .zero_flag(zero_flag), .context_now(context_now), .stack_depth(stack_depth),
  .machine_tick(machine_tick), .periph_tick(periph_tick));

//--- verification/testbench.sv
// Self-checking bench for the core context and stack block.
`timescale 1ns/1ps
module testbench;
  import mccs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n, go, wr, bus_hit, carry_flag, zero_flag, machine_tick, periph_tick;
  logic [7:0] addr, wdata, bus_rdata, acc, ipf, ips, sdf, sds;
  logic [11:0] pc;
  logic [1:0] prog_bank;
  logic [2:0] stack_depth;
  mccs_bus_s bus_req;
  mccs_pc_cmd_s pc_cmd;
  mccs_flag_upd_s flag_upd;
  mccs_ctx_e context_now;
  int bad_count = 0;
  int num_checks = 0;
  int mpc, ctx;
  int stk[$];
  int csave[$];
  int mreg[int];
  int mc[3] = '{0, 0, 0};
  int mz[3] = '{0, 0, 0};
  logic [7:0] alist[8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hD9, 8'hFF, 8'h84, 8'hC9};

  always #20 clk_sys = ~clk_sys;

  mccs_bus_agent agent (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .wr(wr),
    .addr(addr), .wdata(wdata), .bus_req(bus_req));
  mccs_core_state dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
    .pc_cmd(pc_cmd), .flag_upd(flag_upd), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
    .pc(pc), .prog_bank(prog_bank), .accumulator(acc), .index_pointer_first(ipf),
    .index_pointer_second(ips), .short_direct_first(sdf), .short_direct_second(sds),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .context_now(context_now),
    .stack_depth(stack_depth), .machine_tick(machine_tick), .periph_tick(periph_tick));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic hit;
    hit = a inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hD9, 8'hFF};
    @(posedge clk_sys);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    if (w && hit) begin
      mreg[a] = (a == 8'hD9) ? (d & 8'h03) : d;
    end else if (!w) begin
      check(16'(bus_hit), 16'(hit));
      check(16'(bus_rdata), 16'(mreg.exists(a) ? mreg[a] : 0));
    end
  endtask

  task automatic pc_op(input mccs_pc_op_e op, input logic [11:0] t, input logic [7:0] o);
    @(posedge clk_sys);
    pc_cmd <= '{op: op, target: t, offset: o};
    repeat (14) begin
      @(negedge clk_sys);
      if (machine_tick === 1'b1) break;
    end
    @(posedge clk_sys);
    pc_cmd.op <= PC_HOLD;
    case (op)
      PC_INC: mpc = mpc + 1;
      PC_JUMP: mpc = t;
      PC_BRANCH: mpc = mpc + int'($signed(o));
      PC_CALL, PC_INT, PC_NMI: begin
        stk.push_front(mpc);
        if (stk.size() > 6) void'(stk.pop_back());
        mpc = t;
      end
      PC_RET, PC_RETURN_FROM_INTERRUPT: mpc = (stk.size() > 0) ? stk.pop_front() : mpc + 1;
      default: mpc = mpc;
    endcase
    mpc = mpc & 12'hFFF;
    if (op == PC_INT && ctx == 0) begin
      csave.push_back(ctx);
      ctx = 1;
    end
    if (op == PC_NMI && ctx != 2) begin
      csave.push_back(ctx);
      ctx = 2;
    end
    if (op == PC_RETURN_FROM_INTERRUPT) ctx = (csave.size() > 0) ? csave.pop_back() : 0;
    @(negedge clk_sys);
    check(16'(pc), 16'(mpc));
    check(16'(stack_depth), 16'(stk.size()));
    check(16'(context_now), 16'(ctx));
    check(16'(carry_flag), 16'(mc[ctx]));
    check(16'(zero_flag), 16'(mz[ctx]));
  endtask

  task automatic flag_op(input logic ce, cv, bt, bv, ze, input logic [7:0] r);
    @(posedge clk_sys);
    flag_upd <= '{ce, cv, bt, bv, ze, r};
    @(posedge clk_sys);
    flag_upd <= '0;
    if (bt) mc[ctx] = bv;
    else if (ce) mc[ctx] = cv;
    if (ze) mz[ctx] = (r == 8'h00);
    @(negedge clk_sys);
    check(16'(carry_flag), 16'(mc[ctx]));
    check(16'(zero_flag), 16'(mz[ctx]));
  endtask

  initial begin
    #800000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    go = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pc_cmd = '{op: PC_HOLD, target: 12'h000, offset: 8'h00};
    flag_upd = '0;
    void'($urandom(68325));
    mpc = 12'hFFE;
    ctx = 2;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(16'(pc), 16'hFFE);
    check(16'(context_now), 16'(CTX_NMI));
    $display("Reset test done");
    foreach (alist[i]) bus_op(1'b0, alist[i], 8'h00);
    foreach (alist[i]) bus_op(1'b1, alist[i], 8'($urandom));
    foreach (alist[i]) bus_op(1'b0, alist[i], 8'h00);
    check(16'(acc), 16'(mreg[8'hFF]));
    check(16'(sds), 16'(mreg[8'h83]));
    check(16'(ipf), 16'(mreg[8'h80]));
    check(16'(ips), 16'(mreg[8'h81]));
    check(16'(sdf), 16'(mreg[8'h82]));
    check(16'(prog_bank), 16'(mreg[8'hD9]));
    $display("Register test done");
    flag_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    pc_op(PC_INC, 12'h000, 8'h00);
    pc_op(PC_JUMP, 12'($urandom), 8'h00);
    pc_op(PC_BRANCH, 12'h000, 8'hF0);
    pc_op(PC_BRANCH, 12'h000, 8'h10);
    repeat (7) pc_op(PC_CALL, 12'($urandom), 8'h00);
    repeat (7) pc_op(PC_RET, 12'h000, 8'h00);
    pc_op(PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00);
    flag_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h5A);
    pc_op(PC_INT, 12'hFF0, 8'h00);
    flag_op(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    pc_op(PC_NMI, 12'hFFC, 8'h00);
    pc_op(PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00);
    pc_op(PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00);
    $display("Stack and context test done");
    repeat (24) begin
      pc_op(mccs_pc_op_e'($urandom_range(0, 8)), 12'($urandom), 8'($urandom));
      flag_op(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
        8'($urandom_range(0, 2)));
    end
    check(16'(acc), 16'(mreg[8'hFF]));
    check(16'(ips), 16'(mreg[8'h81]));
    $display("Random test done");
    stop_test();
  end
endmodule // testbench

//--- verilog/mccs_core_state.sv
// Programmer-visible core state: data registers, program counter, flags and return stack.
`timescale 1ns/1ps
// Notes on behaviour
// - Eight-bit accumulator, read and written as data location FFh.
// - Two pointer registers mapped at 80h and 81h, used for indirect addressing.
// - Two short-direct registers mapped at 82h and 83h like other registers.
// - Twelve-bit program counter reaching 4096 bytes of program space.
// - Counter advances after fetch; relative branch adds signed offset, writes back.
// - Load target on jump/call, vector on interrupt/reset, pop on return, increment on PC_INC, else hold.
// - Three carry/zero pairs: normal, interrupt, non-maskable; only current pair active.
// - Interrupt entry switches pair; return-from-interrupt restores the previous pair.
// - Pairs keep values across switches; each reachable only in its context.
// - Carry follows carry or borrow, takes tested bit, feeds rotate-left.
// - Zero set when latest arithmetic or logical result is zero, else cleared.
// - Reset starts in non-maskable context using its flag pair.
// - Call or interrupt pushes counter into six-level stack; deepest level lost.
// - Return pops first level into counter, shifting the rest up.
// - Over six pushes saturate; return on empty stack leaves it, continues.
// - Only the counter is stacked; data registers are never saved.
// - Internal clock divided by 13 for core, by 12 for peripherals.
// - Instructions take two, four or five machine cycles of one step each.
// - Bank switch register extends the counter beyond 4096 bytes.
module mccs_core_state #(
  parameter int BANK_W = mccs_pkg::BANK_W_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input mccs_pkg::mccs_bus_s bus_req,
  input mccs_pkg::mccs_pc_cmd_s pc_cmd,
  input mccs_pkg::mccs_flag_upd_s flag_upd,
  output logic [mccs_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_hit,
  output logic [mccs_pkg::PC_W-1:0] pc,
  output logic [BANK_W-1:0] prog_bank,
  output logic [mccs_pkg::DATA_W-1:0] accumulator,
  output logic [mccs_pkg::DATA_W-1:0] index_pointer_first,
  output logic [mccs_pkg::DATA_W-1:0] index_pointer_second,
  output logic [mccs_pkg::DATA_W-1:0] short_direct_first,
  output logic [mccs_pkg::DATA_W-1:0] short_direct_second,
  output logic carry_flag,
  output logic zero_flag,
  output mccs_pkg::mccs_ctx_e context_now,
  output logic [mccs_pkg::DEPTH_W-1:0] stack_depth,
  output logic machine_tick,
  output logic periph_tick
);
  import mccs_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Clock division
  // ----------------------------------------------------------------------
  logic mc_tick;

  mccs_divider #(.DIV(DIV_CORE)) u_core_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n_reg),
    .tick(mc_tick)
  );

  mccs_divider #(.DIV(DIV_PERIPH)) u_periph_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n_reg),
    .tick(periph_tick)
  );

  assign machine_tick = mc_tick;

  // ----------------------------------------------------------------------
  // Data-space registers
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic [DATA_W-1:0] ptr1_reg, ptr1_next;
  logic [DATA_W-1:0] ptr2_reg, ptr2_next;
  logic [DATA_W-1:0] sd1_reg, sd1_next;
  logic [DATA_W-1:0] sd2_reg, sd2_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;

  always_comb begin
    acc_next = acc_reg;
    ptr1_next = ptr1_reg;
    ptr2_next = ptr2_reg;
    sd1_next = sd1_reg;
    sd2_next = sd2_reg;
    bank_next = bank_reg;
    rdata_next = DATA_RESET;
    hit_next = 1'b0;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_ACCUMULATOR: acc_next = bus_req.wdata;
        ADDR_PTR_FIRST: ptr1_next = bus_req.wdata;
        ADDR_PTR_SECOND: ptr2_next = bus_req.wdata;
        ADDR_SHORT_FIRST: sd1_next = bus_req.wdata;
        ADDR_SHORT_SECOND: sd2_next = bus_req.wdata;
        ADDR_BANK: bank_next = bus_req.wdata[BANK_W-1:0];
        default: bank_next = bank_reg;
      endcase
    end
    if (bus_req.rd) begin
      hit_next = 1'b1;
      unique case (bus_req.addr)
        ADDR_ACCUMULATOR: rdata_next = acc_reg;
        ADDR_PTR_FIRST: rdata_next = ptr1_reg;
        ADDR_PTR_SECOND: rdata_next = ptr2_reg;
        ADDR_SHORT_FIRST: rdata_next = sd1_reg;
        ADDR_SHORT_SECOND: rdata_next = sd2_reg;
        ADDR_BANK: rdata_next = DATA_W'(bank_reg);
        default: hit_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      acc_reg <= DATA_RESET;
      ptr1_reg <= DATA_RESET;
      ptr2_reg <= DATA_RESET;
      sd1_reg <= DATA_RESET;
      sd2_reg <= DATA_RESET;
      bank_reg <= '0;
      rdata_reg <= DATA_RESET;
      hit_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      ptr1_reg <= ptr1_next;
      ptr2_reg <= ptr2_next;
      sd1_reg <= sd1_next;
      sd2_reg <= sd2_next;
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  // ----------------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------------
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] stack_reg [STACK_LEVELS];
  logic [PC_W-1:0] stack_next [STACK_LEVELS];
  logic [DEPTH_W-1:0] depth_reg, depth_next;
  logic [PC_W-1:0] branch_sum;
  logic do_push;
  logic do_pop;
  logic op_step;

  assign op_step = mc_tick;

  always_comb begin
    branch_sum = pc_reg + {{(PC_W-OFFS_W){pc_cmd.offset[OFFS_W-1]}}, pc_cmd.offset};
    pc_next = pc_reg;
    do_push = 1'b0;
    do_pop = 1'b0;
    if (op_step) begin
      unique case (pc_cmd.op)
        PC_HOLD: pc_next = pc_reg;
        PC_INC: pc_next = pc_reg + PC_W'(1);
        PC_JUMP: pc_next = pc_cmd.target;
        PC_CALL, PC_INT, PC_NMI: begin
          pc_next = pc_cmd.target;
          do_push = 1'b1;
        end
        PC_BRANCH: pc_next = branch_sum;
        PC_RET, PC_RETURN_FROM_INTERRUPT: begin
          if (depth_reg != DEPTH_RESET) begin
            pc_next = stack_reg[0];
            do_pop = 1'b1;
          end else begin
            pc_next = pc_reg + PC_W'(1);
          end
        end
        default: pc_next = pc_reg;
      endcase
    end
    for (int i = 0; i < STACK_LEVELS; i++) begin
      stack_next[i] = stack_reg[i];
    end
    depth_next = depth_reg;
    if (do_push) begin
      stack_next[0] = pc_reg;
      for (int i = 1; i < STACK_LEVELS; i++) begin
        stack_next[i] = stack_reg[i-1];
      end
      if (depth_reg != DEPTH_W'(STACK_LEVELS)) begin
        depth_next = depth_reg + DEPTH_W'(1);
      end
    end else if (do_pop) begin
      for (int i = 0; i < STACK_LEVELS - 1; i++) begin
        stack_next[i] = stack_reg[i+1];
      end
      stack_next[STACK_LEVELS-1] = stack_reg[STACK_LEVELS-1];
      depth_next = depth_reg - DEPTH_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pc_reg <= PC_RESET;
      depth_reg <= DEPTH_RESET;
      for (int i = 0; i < STACK_LEVELS; i++) begin
        stack_reg[i] <= PC_STACK_RESET;
      end
    end else begin
      pc_reg <= pc_next;
      depth_reg <= depth_next;
      for (int i = 0; i < STACK_LEVELS; i++) begin
        stack_reg[i] <= stack_next[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Contexts and flag pairs
  // ----------------------------------------------------------------------
  mccs_ctx_e ctx_reg, ctx_next;
  mccs_ctx_e save1_reg, save1_next;
  mccs_ctx_e save2_reg, save2_next;
  logic [2:0] carry_reg, carry_next;
  logic [2:0] zero_reg, zero_next;
  logic carry_out_reg, carry_out_next;
  logic zero_out_reg, zero_out_next;

  always_comb begin
    ctx_next = ctx_reg;
    save1_next = save1_reg;
    save2_next = save2_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    if (flag_upd.bit_test_en) begin
      carry_next[ctx_reg] = flag_upd.bit_val;
    end else if (flag_upd.carry_en) begin
      carry_next[ctx_reg] = flag_upd.carry_val;
    end
    if (flag_upd.zero_en) begin
      zero_next[ctx_reg] = (flag_upd.result == DATA_RESET);
    end
    if (op_step) begin
      unique case (pc_cmd.op)
        PC_INT: begin
          if (ctx_reg == CTX_NORMAL) begin
            ctx_next = CTX_INT;
            save2_next = save1_reg;
            save1_next = ctx_reg;
          end
        end
        PC_NMI: begin
          if (ctx_reg != CTX_NMI) begin
            ctx_next = CTX_NMI;
            save2_next = save1_reg;
            save1_next = ctx_reg;
          end
        end
        PC_RETURN_FROM_INTERRUPT: begin
          ctx_next = save1_reg;
          save1_next = save2_reg;
          save2_next = CTX_NORMAL;
        end
        default: ctx_next = ctx_reg;
      endcase
    end
    carry_out_next = carry_next[ctx_next];
    zero_out_next = zero_next[ctx_next];
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctx_reg <= CTX_NMI;
      save1_reg <= CTX_NORMAL;
      save2_reg <= CTX_NORMAL;
      carry_reg <= 3'h0;
      zero_reg <= 3'h0;
      carry_out_reg <= 1'b0;
      zero_out_reg <= 1'b0;
    end else begin
      ctx_reg <= ctx_next;
      save1_reg <= save1_next;
      save2_reg <= save2_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      carry_out_reg <= carry_out_next;
      zero_out_reg <= zero_out_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus_rdata = rdata_reg;
  assign bus_hit = hit_reg;
  assign pc = pc_reg;
  assign prog_bank = bank_reg;
  assign accumulator = acc_reg;
  assign index_pointer_first = ptr1_reg;
  assign index_pointer_second = ptr2_reg;
  assign short_direct_first = sd1_reg;
  assign short_direct_second = sd2_reg;
  assign carry_flag = carry_out_reg;
  assign zero_flag = zero_out_reg;
  assign context_now = ctx_reg;
  assign stack_depth = depth_reg;
endmodule // mccs_core_state

//--- verilog/mccs_divider.sv
// Free-running clock divider that emits one-cycle ticks.
`timescale 1ns/1ps
module mccs_divider #(
  parameter int DIV = 13
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    tick_next = (count_reg == LAST);
    count_next = tick_next ? ZERO : count_reg + CW'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= ZERO;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // mccs_divider

//--- verilog/mccs_pkg.sv
// Shared constants, types and carriers of the core context and stack block.
package mccs_pkg;

  // ----------------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int OFFS_W = 8;
  localparam int STACK_LEVELS = 6;
  localparam int DEPTH_W = 3;
  localparam int BANK_W_DEF = 2;

  // ----------------------------------------------------------------------
  // Data-space addresses of the core registers
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PTR_FIRST = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_PTR_SECOND = 8'h81;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_FIRST = 8'h82;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_SECOND = 8'h83;
  localparam logic [ADDR_W-1:0] ADDR_BANK = 8'hD9;
  localparam logic [ADDR_W-1:0] ADDR_ACCUMULATOR = 8'hFF;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 12'hFFE;
  localparam logic [PC_W-1:0] PC_STACK_RESET = 12'h000;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Clock division
  // ----------------------------------------------------------------------
  localparam int DIV_CORE = 13;
  localparam int DIV_PERIPH = 12;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CTX_NORMAL,
    CTX_INT,
    CTX_NMI
  } mccs_ctx_e;

  typedef enum logic [3:0] {
    PC_HOLD,
    PC_INC,
    PC_JUMP,
    PC_CALL,
    PC_BRANCH,
    PC_INT,
    PC_NMI,
    PC_RET,
    PC_RETURN_FROM_INTERRUPT
  } mccs_pc_op_e;

  typedef struct packed {
    mccs_pc_op_e op;
    logic [PC_W-1:0] target;
    logic [OFFS_W-1:0] offset;
  } mccs_pc_cmd_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mccs_bus_s;

  typedef struct packed {
    logic carry_en;
    logic carry_val;
    logic bit_test_en;
    logic bit_val;
    logic zero_en;
    logic [DATA_W-1:0] result;
  } mccs_flag_upd_s;

endpackage
